// >>> common/hioc_pkg.sv
package hioc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  OFS_ID     = 8'h50;
    localparam logic [7:0]  OFS_CFG    = 8'h54;
    localparam logic [7:0]  OFS_STS    = 8'h58;
    localparam logic [7:0]  OFS_EN     = 8'h5c;
    localparam logic [31:0] RST_CFG    = 32'h0000_0000;
    localparam logic [31:0] RST_STS    = 32'h0000_0000;
    localparam logic [31:0] RST_EN     = 32'h0000_0000;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int HOLD_LSB    = 24;
    localparam int HOLD_W      = 8;
    localparam int RESTART_BIT = 14;
    localparam int ACTIVE_BIT  = 13;
    localparam int MASTER_BIT  = 12;
    localparam int ENABLE_BIT  = 8;
    localparam int POL_BIT     = 4;
    localparam int TYPE_BIT    = 0;
    localparam int POWER_BIT   = 17;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ     = 200;
    localparam int STEP_US     = 10;
    localparam int STEP_CYC    = STEP_US * CLK_MHZ;
endpackage

// >>> src/hioc_tick.sv
`timescale 1ns/1ps
// ****************************************
// Step divider, restartable
// ****************************************
module hioc_tick #(
    parameter int CYCLES = 2000
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic restart,
    output logic      tick
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r + 16'h0001;
        if (restart) begin
            cnt_nxt = 16'h0000;
        end else if (cnt_r == 16'(CYCLES - 1)) begin
            cnt_nxt  = 16'h0000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cnt_r <= 16'h0000;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule

// >>> src/hioc_top.sv
`timescale 1ns/1ps
// How it works
// - Hold-off length in bits 31:24, 10us units
// - Zero length disables hold-off, releases pending
// - New length governs intervals loaded after the write cycle
// - Power event bypasses the hold-off
// - Restart bit clears counter, starts fresh interval
// - Bit 13 reads hold-off in progress
// - Bit 12 shows combined internal line
// - Bit 8 gates pin, status untouched
// - Bit 4 picks push-pull polarity
// - Bit 0 picks open-drain or push-pull
// - Open-drain always active low
// - Polarity and type survive soft reset
// - Identity word read-only, id and revision
// - Config, status, enable at 54h/58h/5Ch, zero reset
// - Writing one clears status bit
module hioc_top #(
    parameter logic [15:0] DESIGN_ID = 16'h0a5c, // Arbitrary value
    parameter logic [15:0] REVISION  = 16'h0000, // Arbitrary value
    parameter int          STEP_CYCLES = hioc_pkg::STEP_CYC
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        soft_reset,
    input  wire logic [7:0]  addr,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [31:0] wdata,
    input  wire logic [31:0] event_set,
    output logic [31:0]      rdata,
    output logic             irq_out,
    output logic             irq_oe
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  hold_r, hold_nxt;
    logic        en_r, en_nxt, pol_r, pol_nxt, typ_r, typ_nxt;
    logic [31:0] sts_r, sts_nxt, ien_r, ien_nxt;
    logic [7:0]  left_r, left_nxt;
    logic        act_r, act_nxt;
    logic        assert_r, assert_nxt;
    logic [31:0] rdata_nxt;
    logic        out_nxt, oe_nxt;
    logic        tick, restart, master, power, cfg_wr;
    logic [31:0] active_src;

    assign cfg_wr = wr && addr == hioc_pkg::OFS_CFG;
    assign restart = cfg_wr && wdata[hioc_pkg::RESTART_BIT];
    assign active_src = sts_r & ien_r;
    assign master = |active_src;
    assign power  = active_src[hioc_pkg::POWER_BIT];

    hioc_tick #(.CYCLES(STEP_CYCLES)) u_tick (
        .clock   (clock),
        .reset   (reset),
        .restart (restart || !act_r),
        .tick    (tick)
    );

    // ****************************************
    // Register writes
    // ****************************************
    always_comb begin
        hold_nxt = hold_r;
        en_nxt   = en_r;
        pol_nxt  = pol_r;
        typ_nxt  = typ_r;
        ien_nxt  = ien_r;
        sts_nxt  = sts_r;
        if (cfg_wr) begin
            hold_nxt = wdata[hioc_pkg::HOLD_LSB +: hioc_pkg::HOLD_W];
            en_nxt   = wdata[hioc_pkg::ENABLE_BIT];
            pol_nxt  = wdata[hioc_pkg::POL_BIT];
            typ_nxt  = wdata[hioc_pkg::TYPE_BIT];
        end
        if (wr && addr == hioc_pkg::OFS_EN) begin
            ien_nxt = wdata;
        end
        if (wr && addr == hioc_pkg::OFS_STS) begin
            sts_nxt = sts_r & ~wdata;
        end
        sts_nxt = sts_nxt | event_set; // Set wins over clear
        if (soft_reset) begin
            hold_nxt = hioc_pkg::RST_CFG[31:24];
            en_nxt   = 1'b0;
            ien_nxt  = hioc_pkg::RST_EN;
            sts_nxt  = hioc_pkg::RST_STS;
        end
    end

    // ****************************************
    // Hold-off sequencing
    // ****************************************
    always_comb begin
        left_nxt   = left_r;
        act_nxt    = act_r;
        assert_nxt = assert_r;
        if (assert_r && !master) begin
            assert_nxt = 1'b0;
            if (hold_r != 8'h00) begin
                act_nxt  = 1'b1;
                left_nxt = hold_r;
            end
        end else if (act_r && tick) begin
            left_nxt = left_r - 8'h01;
            if (left_r == 8'h01) begin
                act_nxt = 1'b0;
            end
        end
        if (restart) begin
            act_nxt  = hold_r != 8'h00;
            left_nxt = hold_r;
        end
        if ((cfg_wr && wdata[hioc_pkg::HOLD_LSB +: hioc_pkg::HOLD_W] == 8'h00) || soft_reset) begin
            act_nxt  = 1'b0;
            left_nxt = 8'h00;
        end
        if (master && (!act_nxt || power)) begin
            assert_nxt = 1'b1;
        end
    end

    // Pin drive computed from next-state values, then registered; open-drain only pulls low
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (addr)
            hioc_pkg::OFS_ID:  rdata_nxt = {DESIGN_ID, REVISION};
            hioc_pkg::OFS_CFG: rdata_nxt = {hold_r, 9'h000, 1'b0, act_r, master, 3'h0,
                                            en_r, 3'h0, pol_r, 3'h0, typ_r};
            hioc_pkg::OFS_STS: rdata_nxt = sts_r;
            hioc_pkg::OFS_EN:  rdata_nxt = ien_r;
            default:           rdata_nxt = 32'h0000_0000;
        endcase
        if (!rd) begin
            rdata_nxt = rdata;
        end
        if (typ_nxt) begin
            oe_nxt  = 1'b1;
            out_nxt = (assert_nxt && en_nxt) ? pol_nxt : !pol_nxt;
        end else begin
            oe_nxt  = assert_nxt && en_nxt;
            out_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pol_r <= 1'b0;
            typ_r <= 1'b0;
        end else begin
            pol_r <= pol_nxt;
            typ_r <= typ_nxt;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hold_r   <= hioc_pkg::RST_CFG[31:24];
            en_r     <= 1'b0;
            sts_r    <= hioc_pkg::RST_STS;
            ien_r    <= hioc_pkg::RST_EN;
            left_r   <= 8'h00;
            act_r    <= 1'b0;
            assert_r <= 1'b0;
            rdata    <= 32'h0000_0000;
            irq_out  <= 1'b0;
            irq_oe   <= 1'b0;
        end else begin
            hold_r   <= hold_nxt;
            en_r     <= en_nxt;
            sts_r    <= sts_nxt;
            ien_r    <= ien_nxt;
            left_r   <= left_nxt;
            act_r    <= act_nxt;
            assert_r <= assert_nxt;
            rdata    <= rdata_nxt;
            irq_out  <= out_nxt;
            irq_oe   <= oe_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_gate_off: assert property (@(posedge clock) disable iff (reset)
        !en_r ##1 !en_r |-> (typ_r ? irq_out == !pol_r : !irq_oe))
        else $error("pin asserted while disabled");
    a_od_low: assert property (@(posedge clock) disable iff (reset)
        !typ_r |-> !irq_out)
        else $error("open drain drove high");
    a_sts_clear: assert property (@(posedge clock) disable iff (reset)
        wr && addr == hioc_pkg::OFS_STS && !soft_reset && wdata[3] && !event_set[3]
        |=> !sts_r[3])
        else $error("status bit not cleared");
    // A new event sets its status bit in the next cycle when soft reset is low
    a_sts_set: assert property (@(posedge clock) disable iff (reset)
        event_set[5] && !soft_reset |=> sts_r[5])
        else $error("event lost");
    a_zero_off: assert property (@(posedge clock) disable iff (reset)
        cfg_wr && wdata[31:24] == 8'h00 |=> !act_r)
        else $error("hold-off not disabled");
    a_restart_go: assert property (@(posedge clock) disable iff (reset)
        restart && !soft_reset && wdata[31:24] != 8'h00 && hold_r != 8'h00 |=> act_r)
        else $error("restart did not start interval");
    a_power_pass: assert property (@(posedge clock) disable iff (reset)
        power && !soft_reset |=> assert_r)
        else $error("power event delayed");
    a_held_off: assert property (@(posedge clock) disable iff (reset)
        act_r && !power && !assert_r && $stable(act_r) |=> !assert_r || !act_r)
        else $error("interrupt passed during hold-off");
    c_holdoff: cover property (@(posedge clock) disable iff (reset) $fell(act_r));
    c_restart: cover property (@(posedge clock) disable iff (reset) restart && act_r);
    c_power:   cover property (@(posedge clock) disable iff (reset) power && act_r);
endmodule

// >>> verification/hioc_host_pin.sv
`timescale 1ns/1ps
// ****************************************
// Host side of the interrupt pin
// ****************************************
module hioc_host_pin (
    input  wire logic irq_out,
    input  wire logic irq_oe,
    output logic      pin
);
    // Board pull-up, so a released open-drain line reads high
    assign pin = irq_oe ? irq_out : 1'b1;
endmodule

// >>> verification/host_irq_output_control_test.sv
`timescale 1ns/1ps
module host_irq_output_control_test;
    localparam logic [7:0] CFG = hioc_pkg::OFS_CFG;
    localparam logic [7:0] STS = hioc_pkg::OFS_STS;
    localparam logic [7:0] EN  = hioc_pkg::OFS_EN;
    logic        clock;
    logic        reset;
    logic        soft_reset;
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
    logic [31:0] event_set;
    logic [31:0] rdata;
    logic        irq_out;
    logic        irq_oe;
    logic        pin;
    logic [31:0] got;
    logic [31:0] xs;
    logic [31:0] en;
    logic [31:0] m;
    int          num_errors;
    int          check_count;
    integer      seed;
    // ****************************************
    // Design and host pin
    // ****************************************
    // Identity value is arbitrary
    hioc_top #(.DESIGN_ID(16'h3c5a), .REVISION(16'h0007), .STEP_CYCLES(4)) uut (
        .clock(clock), .reset(reset), .soft_reset(soft_reset), .addr(addr), .wr(wr),
        .rd(rd), .wdata(wdata), .event_set(event_set), .rdata(rdata),
        .irq_out(irq_out), .irq_oe(irq_oe));
    hioc_host_pin host (.irq_out(irq_out), .irq_oe(irq_oe), .pin(pin));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(negedge clock);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock);
        wr = 1'b0;
    endtask
    // Extra cycle so rdata has landed
    task automatic rd_reg(input logic [7:0] a);
        @(negedge clock);
        addr = a;
        rd = 1'b1;
        @(negedge clock);
        rd = 1'b0;
        @(negedge clock);
        got = rdata;
    endtask
    task automatic pulse(input logic [31:0] v);
        @(negedge clock);
        event_set = v;
        xs = xs | v;
        @(negedge clock);
        event_set = 32'h0;
        repeat (2) @(negedge clock);
    endtask
    // Expected host level: active drives pol when push-pull, else low
    function automatic logic [31:0] lvl(input logic act, input logic [31:0] c);
        return {31'h0, act ~^ (c[0] & c[4])};
    endfunction
    task automatic complete_run();
        if (num_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #30000;
        num_errors++;
        complete_run();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        seed = 32'h22beed11;
        {reset, soft_reset, wr, rd, addr, wdata, event_set, xs} = {1'b1, 75'h0, 32'h0};
        num_errors = 0;
        check_count = 0;
        repeat (5) @(negedge clock);
        reset = 1'b0;
        rd_reg(CFG);
        check(got, hioc_pkg::RST_CFG);
        rd_reg(STS);
        check(got, hioc_pkg::RST_STS);
        rd_reg(EN);
        check(got, hioc_pkg::RST_EN);
        wr_reg(hioc_pkg::OFS_ID, 32'hffff_ffff);
        rd_reg(hioc_pkg::OFS_ID);
        check(got, 32'h3c5a_0007);
        wr_reg(8'h60, 32'hffff_ffff);
        rd_reg(8'h60);
        check(got, 32'h0);
        for (int i = 0; i < 16; i++) begin
            en = $random(seed);
            m = $random(seed);
            wr_reg(EN, en);
            pulse($random(seed));
            rd_reg(STS);
            check(got, xs);
            rd_reg(CFG);
            check({31'h0, got[12]}, {31'h0, |(xs & en)});
            wr_reg(STS, m);
            xs = xs & ~m;
        end
        wr_reg(STS, 32'hffff_ffff);
        xs = 32'h0;
        wr_reg(EN, 32'h0002_0001);
        wr_reg(CFG, 32'h11);
        pulse(32'h1);
        check({31'h0, pin}, lvl(1'b0, 32'h11));
        wr_reg(CFG, 32'h111);
        repeat (2) @(negedge clock);
        check({31'h0, pin}, lvl(1'b1, 32'h111));
        wr_reg(CFG, 32'h101);
        repeat (2) @(negedge clock);
        check({31'h0, pin}, lvl(1'b1, 32'h101));
        wr_reg(CFG, 32'h110);
        repeat (2) @(negedge clock);
        check({30'h0, pin, irq_oe}, 32'h1);
        @(negedge clock);
        soft_reset = 1'b1;
        @(negedge clock);
        soft_reset = 1'b0;
        rd_reg(CFG);
        check(got, 32'h10);
        wr_reg(EN, 32'h0002_0001);
        wr_reg(CFG, 32'h0300_0111);
        pulse(32'h1);
        wr_reg(STS, 32'h1);
        rd_reg(CFG);
        check(got & 32'h6000, 32'h2000);
        pulse(32'h1);
        check({31'h0, pin}, 32'h0);
        wr_reg(CFG, 32'h111);
        repeat (2) @(negedge clock);
        check({31'h0, pin}, 32'h1);
        wr_reg(CFG, 32'h0300_0111);
        wr_reg(STS, 32'h1);
        pulse(32'h0002_0000);
        check({31'h0, pin}, 32'h1);
        wr_reg(STS, 32'h0002_0000);
        repeat (14) @(negedge clock);
        wr_reg(CFG, 32'h0300_4111);
        pulse(32'h1);
        check({31'h0, pin}, 32'h0);
        repeat (12) @(negedge clock);
        check({31'h0, pin}, 32'h1);
        complete_run();
    end
endmodule
